// >>> mark_delay_timer.v
// one-shot microsecond delay used to postpone a trigger pulse
// assumes a one-cycle microsecond tick from the same clock domain
`timescale 1ns/100ps
`default_nettype none

module mark_delay_timer #(
	parameter WIDTH = 23
) (
	input wire core_clk,
	input wire arst_n,
	input wire usTick,
	input wire start,
	input wire [WIDTH-1:0] delayUs,
	output reg busy,
	output reg fire
);

// ----------------------------------------------------------------
// countdown
// ----------------------------------------------------------------
reg [WIDTH-1:0] remain_r; // microseconds still to wait

// start is ignored while busy: one pending event at a time
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		remain_r <= {WIDTH{1'b0}};
		busy <= 1'b0;
		fire <= 1'b0;
	end
	else
	begin
		fire <= 1'b0;
		if (!busy)
		begin
			if (start)
			begin
				// zero delay fires on the next edge
				if (delayUs == {WIDTH{1'b0}})
					fire <= 1'b1;
				else
				begin
					remain_r <= delayUs;
					busy <= 1'b1;
				end
			end
		end
		else if (usTick)
		begin
			if (remain_r == {{(WIDTH-1){1'b0}}, 1'b1})
			begin
				busy <= 1'b0;
				fire <= 1'b1;
			end
			remain_r <= remain_r - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
end

endmodule

`default_nettype wire

// >>> mark_detect_defines.vh
// constants for the mark detection input front end
// assumes a 50 MHz core clock and a 32-bit word register port
`ifndef MARK_DETECT_DEFINES_VH
`define MARK_DETECT_DEFINES_VH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define NS_PER_US 1000
`define CYC_PER_US (`NS_PER_US / `CLK_PERIOD_NS)
// last divider count of a microsecond, sized for the 6-bit divider
`define US_DIV_LAST 6'h31

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_CTRL 5'h00
`define OFF_COMP 5'h04
`define OFF_STAT 5'h08
`define OFF_MASK 5'h0C
`define OFF_STAMP 5'h10
`define OFF_ACC 5'h14
`define OFF_INPUT 5'h18

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTL_ENABLE 0
`define CTL_TRAIL 1
`define CTL_SRC_LO 2
`define CTL_SRC_HI 3
`define CTL_ESTIMATE 4
`define CTL_INDIRECT 5
`define CTL_MAINBASE 6
`define CTL_MODEVAR 7
`define CTL_RESP_LO 8
`define CTL_RESP_HI 9
`define CTL_LONGCYC 10
`define CTL_SIG_LO 12
`define CTL_SIG_HI 15
`define CTL_RESET 32'h0000_0000

// trigger source codes
`define SRC_BUILTIN 2'h0
`define SRC_MODULE 2'h1
`define SRC_BITVAR 2'h2

// ----------------------------------------------------------------
// status / mask bits
// ----------------------------------------------------------------
`define ST_DETECT 0
`define ST_MODEOFF 1
`define ST_CLAMP 2
`define ST_WIDTH 3

// ----------------------------------------------------------------
// limits and accuracies (microseconds)
// ----------------------------------------------------------------
`define COMP_MAX_US 32'sd5000000
`define COMP_MIN_US (-32'sd5000000)
`define MODE_MAX 32'sd8192
`define MODE_MIN (-32'sd8192)
`define ACC_BUILTIN_US 16'h001E
`define ACC_RESP04_US 16'h0045
`define ACC_RESP06_US 16'h0085
`define ACC_RESP10_US 16'h0105
`define ACC_CYC222_US 16'h00DE
`define ACC_CYC444_US 16'h01BC

`endif

// >>> mark_detect_input_compensation.v
// mark detection front end: trigger select, edge, compensation
// assumes one 50 MHz clock, a periodic operation cycle tick from
// the motion core, and a simple one-cycle register port
//
// Notes on behaviour
// - leading edge mode triggers on inactive-to-active
// - trailing edge mode triggers on active-to-inactive
// - builtin inputs 1..4 usable, 30 us accuracy
// - module input accuracy follows response time setting
// - module inputs only work on main base
// - detect even while input used for homing
// - mode variable outside +-8192 disables detection
// - bit variable accuracy 222 or 444 us
// - builtin group offsets 4..F read zero
// - signed compensation shifts trigger instant
// - estimate invalid forces compensation zero
// - compensation clamped to +-5000000 us
// - indirect compensation re-read every operation cycle
// - unassigned module inputs may be trigger sources
`timescale 1ns/100ps
`default_nettype none
`include "mark_detect_defines.vh"

module mark_detect_input_compensation #(
	parameter MOD_BITS = 8,
	parameter VAR_BITS = 16
) (
	input wire core_clk,
	input wire arst_n,
	input wire [4:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData,
	input wire [3:0] builtinDigitalInput,
	input wire [MOD_BITS-1:0] proximityOrSpeedChangeInput,
	input wire [VAR_BITS-1:0] specialRelayBit,
	input wire opCycleTick,
	input wire [31:0] compWordPair,
	input wire [31:0] modeSettingVar,
	output reg markPulse,
	output reg [31:0] markStamp,
	output reg irq
);

// ----------------------------------------------------------------
// helper functions
// ----------------------------------------------------------------
// saturate a signed value into the compensation window
function [31:0] clampComp;
	input [31:0] v;
	begin
		if ($signed(v) > `COMP_MAX_US)
			clampComp = `COMP_MAX_US;
		else if ($signed(v) < `COMP_MIN_US)
			clampComp = `COMP_MIN_US;
		else
			clampComp = v;
	end
endfunction

// true when a value lies outside the window
function outOfWindow;
	input [31:0] v;
	input [31:0] lo;
	input [31:0] hi;
	begin
		outOfWindow = ($signed(v) < $signed(lo)) ||
			($signed(v) > $signed(hi));
	end
endfunction

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [3:0] diMeta_r; // first stage, read only by second
reg [3:0] diSync_r; // safe builtin inputs
reg [MOD_BITS-1:0] modMeta_r; // first stage
reg [MOD_BITS-1:0] modSync_r; // safe module inputs

// two flops before anything looks at a pin
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		diMeta_r <= 4'h0;
		diSync_r <= 4'h0;
		modMeta_r <= {MOD_BITS{1'b0}};
		modSync_r <= {MOD_BITS{1'b0}};
	end
	else
	begin
		diMeta_r <= builtinDigitalInput;
		diSync_r <= diMeta_r;
		modMeta_r <= proximityOrSpeedChangeInput;
		modSync_r <= modMeta_r;
	end
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [31:0] ctrl_r; // steering bits
reg [31:0] compDirect_r; // direct compensation value
reg [`ST_WIDTH-1:0] status_r; // sticky events
reg [`ST_WIDTH-1:0] mask_r; // interrupt enables
reg [31:0] compCyc_r; // compensation frozen per op cycle
reg modeOff_r; // mode variable out of range
reg [31:0] usCount_r; // free microsecond timestamp
reg [5:0] usDiv_r; // clock to microsecond divider
reg usTick_r; // one cycle per microsecond
reg trigLevel_r; // previous trigger level
reg trigValid_r; // previous level is meaningful
reg [31:0] pendStamp_r; // stamp waiting on delayed fire
reg [15:0] accuracy; // current accuracy, combinational
reg trigLevel; // selected trigger level
reg trigSample; // level may be compared this cycle
reg sourceOk; // selection is usable

wire enable = ctrl_r[`CTL_ENABLE];
wire trail = ctrl_r[`CTL_TRAIL];
wire [1:0] src = ctrl_r[`CTL_SRC_HI:`CTL_SRC_LO];
wire [3:0] sigNo = ctrl_r[`CTL_SIG_HI:`CTL_SIG_LO];
wire [1:0] resp = ctrl_r[`CTL_RESP_HI:`CTL_RESP_LO];
wire [15:0] builtinGroup = {12'h000, diSync_r};

// ----------------------------------------------------------------
// trigger source selection
// ----------------------------------------------------------------
always @*
begin
	trigLevel = 1'b0;
	trigSample = 1'b0;
	sourceOk = 1'b0;
	accuracy = `ACC_BUILTIN_US;
	case (src)
	`SRC_BUILTIN:
	begin
		// only offsets 0..3 carry a real input
		trigLevel = builtinGroup[sigNo];
		trigSample = 1'b1;
		sourceOk = (sigNo < 4'h4);
		accuracy = `ACC_BUILTIN_US;
	end
	`SRC_MODULE:
	begin
		// axis use of the pin is irrelevant here
		trigLevel = modSync_r[sigNo[2:0]];
		trigSample = 1'b1;
		sourceOk = ctrl_r[`CTL_MAINBASE] && (sigNo < 4'h8);
		case (resp)
		2'h0: accuracy = `ACC_RESP04_US;
		2'h1: accuracy = `ACC_RESP06_US;
		default: accuracy = `ACC_RESP10_US;
		endcase
	end
	`SRC_BITVAR:
	begin
		// bit variables only change once per operation cycle
		trigLevel = specialRelayBit[sigNo];
		trigSample = opCycleTick;
		sourceOk = 1'b1;
		accuracy = ctrl_r[`CTL_LONGCYC] ? `ACC_CYC444_US :
			`ACC_CYC222_US;
	end
	default:
	begin
		sourceOk = 1'b0;
	end
	endcase
end

// ----------------------------------------------------------------
// edge qualification
// ----------------------------------------------------------------
wire qualified = enable && sourceOk && !modeOff_r && trigSample;
wire edgeHit = qualified && trigValid_r &&
	(trail ? (trigLevel_r && !trigLevel) :
	(!trigLevel_r && trigLevel));

// remember the last level; restart after any reconfiguration
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		trigLevel_r <= 1'b0;
		trigValid_r <= 1'b0;
	end
	else if (regWr && regAddr == `OFF_CTRL)
		trigValid_r <= 1'b0; // avoids a false edge on reselect
	else if (qualified)
	begin
		trigLevel_r <= trigLevel;
		trigValid_r <= 1'b1;
	end
	else if (!enable || !sourceOk || modeOff_r)
		trigValid_r <= 1'b0;
end

// ----------------------------------------------------------------
// operation cycle sampling of variables
// ----------------------------------------------------------------
wire [31:0] compRaw = ctrl_r[`CTL_INDIRECT] ? compWordPair :
	compDirect_r;
wire [31:0] compEff = ctrl_r[`CTL_ESTIMATE] ? clampComp(compRaw) :
	32'h0000_0000;
wire compClamped = ctrl_r[`CTL_ESTIMATE] &&
	outOfWindow(compRaw, `COMP_MIN_US, `COMP_MAX_US);
wire modeBad = ctrl_r[`CTL_MODEVAR] &&
	outOfWindow(modeSettingVar, `MODE_MIN, `MODE_MAX);

// variables are taken once per cycle, steady in between
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		compCyc_r <= 32'h0000_0000;
		modeOff_r <= 1'b0;
	end
	else if (opCycleTick)
	begin
		compCyc_r <= compEff;
		modeOff_r <= modeBad;
	end
end

// ----------------------------------------------------------------
// microsecond time base
// ----------------------------------------------------------------
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		usDiv_r <= 6'h00;
		usTick_r <= 1'b0;
		usCount_r <= 32'h0000_0000;
	end
	else
	begin
		usTick_r <= 1'b0;
		if (usDiv_r == `US_DIV_LAST)
		begin
			usDiv_r <= 6'h00;
			usTick_r <= 1'b1;
			usCount_r <= usCount_r + 32'h0000_0001;
		end
		else
			usDiv_r <= usDiv_r + 6'h01;
	end
end

// ----------------------------------------------------------------
// compensation: positive backdates, negative postpones
// ----------------------------------------------------------------
// a positive value cannot fire early, so the stamp carries it;
// a negative value really delays the pulse by that many us
wire compNeg = compCyc_r[31];
wire [31:0] compMag = compNeg ? (32'h0000_0000 - compCyc_r) : 32'h0000_0000;
wire delayBusy;
wire delayFire;

mark_delay_timer #(
	.WIDTH(23)
) delayUnit (
	.core_clk(core_clk),
	.arst_n(arst_n),
	.usTick(usTick_r),
	.start(edgeHit && compNeg),
	.delayUs(compMag[22:0]),
	.busy(delayBusy),
	.fire(delayFire)
);

// at most one pulse per event, none for a delayed edge while busy; the stamp is the compensated instant
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		markPulse <= 1'b0;
		markStamp <= 32'h0000_0000;
		pendStamp_r <= 32'h0000_0000;
	end
	else
	begin
		markPulse <= 1'b0;
		if (delayFire)
		begin
			markPulse <= 1'b1;
			markStamp <= pendStamp_r;
		end
		else if (edgeHit && !compNeg)
		begin
			markPulse <= 1'b1;
			markStamp <= usCount_r - compCyc_r;
		end
		if (edgeHit && compNeg && !delayBusy)
			pendStamp_r <= usCount_r - compCyc_r;
	end
end

// ----------------------------------------------------------------
// register writes, sticky status and interrupt
// ----------------------------------------------------------------
wire [`ST_WIDTH-1:0] events = {compClamped && opCycleTick,
	modeBad && opCycleTick, edgeHit};
wire [`ST_WIDTH-1:0] w1c = (regWr && regAddr == `OFF_STAT) ?
	regWrData[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

// a new event in the clearing cycle survives the clear
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		ctrl_r <= `CTL_RESET;
		compDirect_r <= 32'h0000_0000;
		status_r <= {`ST_WIDTH{1'b0}};
		mask_r <= {`ST_WIDTH{1'b0}};
		irq <= 1'b0;
	end
	else
	begin
		if (regWr && regAddr == `OFF_CTRL)
			ctrl_r <= regWrData;
		if (regWr && regAddr == `OFF_COMP)
			compDirect_r <= regWrData;
		if (regWr && regAddr == `OFF_MASK)
			mask_r <= regWrData[`ST_WIDTH-1:0];
		status_r <= (status_r & ~w1c) | events;
		irq <= |(((status_r & ~w1c) | events) & mask_r);
	end
end

// ----------------------------------------------------------------
// register reads, data in the following cycle
// ----------------------------------------------------------------
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
		regRdData <= 32'h0000_0000;
	else if (regRd)
	begin
		case (regAddr)
		`OFF_CTRL: regRdData <= ctrl_r;
		`OFF_COMP: regRdData <= compCyc_r;
		`OFF_STAT: regRdData <= {29'h0000_0000, status_r};
		`OFF_MASK: regRdData <= {29'h0000_0000, mask_r};
		`OFF_STAMP: regRdData <= markStamp;
		`OFF_ACC: regRdData <= {16'h0000, accuracy};
		`OFF_INPUT: regRdData <= {16'h0000, builtinGroup};
		default: regRdData <= 32'h0000_0000; // unmapped reads zero
		endcase
	end
	else
		regRdData <= 32'h0000_0000;
end

endmodule

`default_nettype wire

// >>> mark_detect_input_compensation_assertions.sv
// port checker for the mark detection front end
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/100ps
`default_nettype none
module mark_detect_input_compensation_assertions #(
	parameter MOD_BITS = 8,
	parameter VAR_BITS = 16
) (
	input wire core_clk,
	input wire arst_n,
	input wire [4:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	input wire [31:0] regRdData,
	input wire [3:0] builtinDigitalInput,
	input wire [MOD_BITS-1:0] proximityOrSpeedChangeInput,
	input wire [VAR_BITS-1:0] specialRelayBit,
	input wire opCycleTick,
	input wire [31:0] compWordPair,
	input wire [31:0] modeSettingVar,
	input wire markPulse,
	input wire [31:0] markStamp,
	input wire irq
);
	// ----------------------------------------
	// control shadow
	// ----------------------------------------
	logic [31:0] ctrlR;
	logic [3:0] ageR;
	logic tickR;
	wire ctrlWr = regWr && regAddr == 5'h00;
	// edge checks only once history and compensation have settled
	wire diArm = ctrlR[0] && ctrlR[3:2] == 2'h0 && !ctrlR[4] &&
		!ctrlR[7] && ctrlR[15:14] == 2'h0 && ageR == 4'hF && tickR;
	wire selBit = builtinDigitalInput[ctrlR[13:12]];
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrlR <= 32'h0;
			ageR <= 4'h0;
			tickR <= 1'h0;
		end
		else if (ctrlWr)
		begin
			ctrlR <= regWrData;
			ageR <= 4'h0;
			tickR <= 1'h0;
		end
		else
		begin
			ageR <= ageR == 4'hF ? ageR : ageR + 4'h1;
			tickR <= tickR | opCycleTick;
		end
	end
	// accuracy in microseconds for a control word
	function automatic [31:0] accExp(input [31:0] cw);
		if (cw[3:2] == 2'h0)
			accExp = 32'h1E;
		else if (cw[3:2] == 2'h1)
			accExp = cw[9:8] == 2'h0 ? 32'h45 :
				cw[9:8] == 2'h1 ? 32'h85 : 32'h105;
		else
			accExp = cw[10] ? 32'h1BC : 32'hDE;
	endfunction
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence riseSeen;
		diArm && !ctrlR[1] && $rose(selBit);
	endsequence
	sequence fallTrail;
		diArm && ctrlR[1] && $fell(selBit);
	endsequence
	sequence fallLead;
		diArm && !ctrlR[1] && $fell(selBit);
	endsequence
	pulse_single_a: assert property (markPulse |=> !markPulse)
		else $error("detect pulse wider than one cycle");
	stamp_hold_a: assert property (!markPulse |-> $stable(markStamp))
		else $error("stamp moved without a pulse");
	read_idle_a: assert property (!regRd |=> regRdData == 32'h0)
		else $error("read data not idle");
	accuracy_read_a: assert property (regRd && regAddr == 5'h14 &&
		ctrlR[3:2] != 2'h3 |=> regRdData == accExp($past(ctrlR)))
		else $error("accuracy value wrong");
	group_zero_a: assert property (regRd && regAddr == 5'h18
		|=> regRdData[31:4] == 28'h0)
		else $error("unused group bits not zero");
	comp_zero_a: assert property (regRd && regAddr == 5'h04 &&
		!ctrlR[4] && tickR |=> regRdData == 32'h0)
		else $error("compensation not forced to zero");
	lead_edge_a: assert property (riseSeen |-> ##[2:4] markPulse)
		else $error("no pulse on leading edge");
	trail_edge_a: assert property (fallTrail
		|-> ##[2:4] markPulse)
		else $error("no pulse on trailing edge");
	wrong_edge_a: assert property (fallLead
		|=> (!markPulse) [*4])
		else $error("pulse on the wrong edge");
endmodule
bind mark_detect_input_compensation mark_detect_input_compensation_assertions
	#(.MOD_BITS(MOD_BITS), .VAR_BITS(VAR_BITS)) chk_i (
	.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .builtinDigitalInput(builtinDigitalInput),
	.proximityOrSpeedChangeInput(proximityOrSpeedChangeInput),
	.specialRelayBit(specialRelayBit), .opCycleTick(opCycleTick),
	.compWordPair(compWordPair), .modeSettingVar(modeSettingVar),
	.markPulse(markPulse), .markStamp(markStamp), .irq(irq));
`default_nettype wire

// >>> mark_detect_input_compensation_test.sv
// self-checking bench for the mark detection front end
// assumes the sensor model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "mark_detect_defines.vh"
module mark_detect_input_compensation_test;
	logic core_clk = 1'h0;
	logic arst_n = 1'h0;
	logic [4:0] regAddr = 5'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'h0;
	logic regRd = 1'h0;
	logic slow = 1'h0;
	logic [3:0] diCmd = 4'h0;
	logic [7:0] modCmd = 8'h00;
	logic [15:0] specialRelayBit = 16'h0;
	logic opCycleTick = 1'h0;
	logic [31:0] compWordPair = 32'h0;
	logic [31:0] modeSettingVar = 32'h0;
	wire [31:0] regRdData;
	wire [3:0] diPin;
	wire [7:0] modPin;
	wire markPulse;
	wire irq;
	wire [31:0] markStamp;
	int fails = 0;
	int compares = 0;
	int pulses = 0;
	int tickCnt = 0;
	int n;
	int p0;
	int s;
	logic [31:0] d;
	logic [31:0] c;
	logic [31:0] accCfg [7] = '{32'h0, 32'h4, 32'h104, 32'h204, 32'h304,
		32'h8, 32'h408};
	int accUs [7] = '{30, 69, 133, 261, 261, 222, 444};
	int modeVal [4] = '{8192, -8192, 8193, -8193};
	int compIn [4] = '{6000000, -6000000, 5000000, -5000001};
	int compExp [4] = '{5000000, -5000000, 5000000, -5000000};
	mark_sensor_model mark_sensor_model_i (.core_clk(core_clk), .slow(slow),
		.diCmd(diCmd), .modCmd(modCmd), .diPin(diPin), .modPin(modPin));
	mark_detect_input_compensation mark_detect_input_compensation_i (
		.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .builtinDigitalInput(diPin),
		.proximityOrSpeedChangeInput(modPin),
		.specialRelayBit(specialRelayBit), .opCycleTick(opCycleTick),
		.compWordPair(compWordPair), .modeSettingVar(modeSettingVar),
		.markPulse(markPulse), .markStamp(markStamp), .irq(irq));
	// ----------------------------------------
	// clock, operation cycle, pulse count
	// ----------------------------------------
	initial forever #10 core_clk = ~core_clk;
	// short operation cycle keeps the run brief
	always @(posedge core_clk)
	begin
		tickCnt <= tickCnt == 19 ? 0 : tickCnt + 1;
		opCycleTick <= tickCnt == 19;
		if (markPulse === 1'h1)
			pulses <= pulses + 1;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test();
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input [31:0] got, input [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input [4:0] a, input [31:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'h1;
		@(posedge core_clk);
		regWr <= 1'h0;
	endtask
	task automatic rd(input [4:0] a, output [31:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge core_clk);
		regRd <= 1'h0;
		#1 v = regRdData;
	endtask
	// long enough for compensation to take a new operation cycle
	task automatic settle();
		repeat (45) @(posedge core_clk);
	endtask
	task automatic drive(input int src, input int idx, input bit v);
		@(posedge core_clk);
		if (src == 0)
			diCmd[idx] <= v;
		else if (src == 1)
			modCmd[idx] <= v;
		else
			specialRelayBit[idx] <= v;
		repeat (60) @(posedge core_clk);
	endtask
	// reference model: one pulse per qualified edge, none otherwise
	task automatic edgeChk(input [31:0] cw, input bit v, input bit off);
		int q;
		bit e;
		q = pulses;
		e = cw[0] && !off && (cw[3:2] != 2'h1 || cw[6]) && (v ^ cw[1]);
		drive(cw[3:2], cw[15:12], v);
		chk(pulses - q, {31'h0, e});
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'hF4AB));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'h1;
		for (int i = 0; i < 7; i++)
		begin
			wr(5'h00, accCfg[i]);
			rd(5'h14, d);
			chk(d, accUs[i]);
		end
		diCmd <= 4'($urandom);
		repeat (6) @(posedge core_clk);
		rd(5'h18, d);
		chk(d, {28'h0, diCmd});
		wr(5'h0C, 32'h1);
		for (int k = 0; k < 8; k++)
		begin
			s = k < 6 ? k / 2 : 1;
			slow <= k[0];
			c = 32'(1 | (k % 2) << 1 | s << 2 | (k < 6) << 6 |
				($urandom % (4 << s)) << 12);
			drive(s, c[15:12], c[1]);
			wr(5'h00, c);
			settle();
			edgeChk(c, !c[1], 1'h0);
			edgeChk(c, c[1], 1'h0);
		end
		rd(5'h08, d);
		chk({31'h0, d[0]}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(5'h08, 32'h7);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(5'h00, 32'h11);
		for (int i = 0; i < 4; i++)
		begin
			wr(5'h04, compIn[i]);
			// clear only once the new value is in place
			wr(5'h08, 32'h4);
			settle();
			rd(5'h04, d);
			chk(d, compExp[i]);
			rd(5'h08, d);
			chk({31'h0, d[2]}, {31'h0, i != 2});
		end
		wr(5'h00, 32'h01);
		settle();
		rd(5'h04, d);
		chk(d, 32'h0);
		// even-aligned word pair value, re-read each cycle
		wr(5'h00, 32'h31);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge core_clk);
			compWordPair <= 32'($urandom % 10000000) - 32'd5000000;
			settle();
			rd(5'h04, d);
			chk(d, compWordPair);
		end
		// negative setting delays the pulse, as a real-value user would
		drive(0, 0, 1'h0);
		wr(5'h00, 32'h11);
		wr(5'h04, -32'sd5);
		settle();
		p0 = pulses;
		// microseconds since start, for the expected stamp
		s = int'($time / 1000);
		diCmd[0] <= 1'h1;
		n = 0;
		while (pulses == p0 && n < 400)
		begin
			@(posedge core_clk);
			n++;
		end
		chk({31'h0, n >= 4 * `CYC_PER_US && n <= 5 * `CYC_PER_US + 8},
			32'h1);
		// stamp is the edge instant minus the -5 us setting, 1 us slack
		chk({31'h0, (markStamp - s - 5) < 2}, 32'h1);
		drive(0, 0, 1'h0);
		for (int i = 0; i < 4; i++)
		begin
			modeSettingVar <= modeVal[i];
			wr(5'h00, 32'h81);
			settle();
			edgeChk(32'h81, 1'h1, i > 1);
			edgeChk(32'h81, 1'h0, i > 1);
			rd(5'h08, d);
			chk({31'h0, d[1]}, {31'h0, i > 1});
			wr(5'h08, 32'h2);
		end
		stop_test();
	end
	// hang guard, about six times the expected run
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire

// >>> mark_sensor_model.sv
// sensor pin model feeding the built-in and module inputs
// assumes level commands from the bench on the core clock
`timescale 1ns/100ps
`default_nettype none
module mark_sensor_model (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic [3:0] diCmd,
	input wire logic [7:0] modCmd,
	output logic [3:0] diPin,
	output logic [7:0] modPin
);
	// one or two cycles of sensor lag
	logic [11:0] lagR = 12'h000;
	always @(posedge core_clk)
	begin
		lagR <= {modCmd, diCmd};
		{modPin, diPin} <= slow ? lagR : {modCmd, diCmd};
	end
endmodule
`default_nettype wire
